// ==== rtl/cfg_loader_consts.svh ====
`ifndef CFG_LOADER_CONSTS_SVH
`define CFG_LOADER_CONSTS_SVH
// =====================================================
// timing
`define CLK_FREQ_HZ        40000000
`define POR_LONG_MS        100
`define POR_SHORT_MS       2
`define POR_LONG_CYCLES    ((`CLK_FREQ_HZ / 1000) * `POR_LONG_MS)
`define POR_SHORT_CYCLES   ((`CLK_FREQ_HZ / 1000) * `POR_SHORT_MS)
`define INIT_CYCLES        16
// =====================================================
// test-port instruction codes
`define IR_WIDTH           10
`define IR_RECONFIG_PULSE  10'h001
// =====================================================
// sizes
`define CFG_WORDS_DEFAULT  1024
`define IO_WIDTH_DEFAULT   8
`endif

// ==== rtl/cfg_loader_pkg.sv ====
package cfg_loader_pkg;
  // configuration schemes
  typedef enum logic [2:0] {
    scheme_memory,
    scheme_passive_serial,
    scheme_passive_parallel_async,
    scheme_fast_passive_parallel,
    scheme_test_port
  } scheme_e;

  typedef enum logic [2:0] {
    st_por,
    st_wait_chain,
    st_config,
    st_init,
    st_user
  } phase_e;

  // one configuration byte offered by the loading party
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } cfg_word_s;

  // parallel-async pins as seen by the core
  typedef struct packed {
    logic       chip_select_n;
    logic       write_strobe_n;
    logic       read_strobe_n;
    logic [7:0] data;
  } ppa_pins_s;
endpackage

// ==== rtl/cfg_store.sv ====
`timescale 1ns/1ps
module cfg_store #(
  parameter int DEPTH = 1024,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock
  input  wire logic          clk_i,
  input  wire logic          ce_i,
  // write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [7:0]    wdata_i,
  // read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [7:0]    rdata_o
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

// ==== rtl/cfg_mode_ctrl.sv ====
`timescale 1ns/1ps
`include "cfg_loader_consts.svh"
module cfg_mode_ctrl #(
  parameter int CFG_WORDS    = `CFG_WORDS_DEFAULT,
  parameter int IO_WIDTH     = `IO_WIDTH_DEFAULT,
  parameter int POR_LONG     = `POR_LONG_CYCLES,
  parameter int POR_SHORT    = `POR_SHORT_CYCLES
) (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         ce_i,
  // straps
  input  wire logic                         reset_delay_select_i,
  input  wire logic                         weak_bias_select_n_i,
  input  wire cfg_loader_pkg::scheme_e      scheme_i,
  // reconfiguration
  input  wire logic                         reconfig_request_n_i,
  input  wire logic [`IR_WIDTH-1:0]         test_ir_i,
  // chain
  input  wire logic                         chain_config_enable_in_n_i,
  output logic                              chain_config_enable_out_n_o,
  // serial, fast parallel, memory and test-port byte streams
  input  wire logic                         serial_data_i,
  input  wire logic                         serial_valid_i,
  input  wire cfg_loader_pkg::cfg_word_s    par_word_i,
  input  wire cfg_loader_pkg::cfg_word_s    mem_word_i,
  input  wire cfg_loader_pkg::cfg_word_s    test_word_i,
  // parallel async pins
  input  wire cfg_loader_pkg::ppa_pins_s    ppa_i,
  output logic                              parallel_load_ready_o,
  // user I/O
  input  wire logic [IO_WIDTH-1:0]          user_out_i,
  input  wire logic [IO_WIDTH-1:0]          user_oe_n_i,
  output logic      [IO_WIDTH-1:0]          io_out_o,
  output logic      [IO_WIDTH-1:0]          io_oe_n_o,
  output logic                              io_pullup_en_o,
  output logic                              ppa_pins_owned_o,
  // status and readback
  output logic                              user_mode_o,
  output logic                              init_reset_o,
  input  wire logic [$clog2(CFG_WORDS)-1:0] cfg_raddr_i,
  output logic      [7:0]                   cfg_rdata_o
);
  import cfg_loader_pkg::*;

  localparam int AW   = $clog2(CFG_WORDS);
  // one counter serves the power-on wait and the init phase, so size it for both
  localparam int CMAX = (POR_LONG > `INIT_CYCLES) ? POR_LONG : `INIT_CYCLES;
  localparam int CW   = $clog2(CMAX + 1);

  // =====================================================
  // state
  typedef struct packed {
    phase_e             phase;
    logic [CW-1:0]      count;
    logic [AW:0]        words;
    logic [2:0]         bits;
    logic [7:0]         shift;
    logic               ws_last;
    logic               ir_hit_last;
    logic               chain_done;
    logic               por_loaded;
    logic [IO_WIDTH-1:0] out_q;
    logic [IO_WIDTH-1:0] oe_n_q;
  } state_s;

  state_s state;
  state_s next_state;

  logic       wr_en;
  logic [7:0] wr_data;
  logic       ir_hit;
  logic       reconfig;
  logic       ws_fall;
  logic       src_valid;
  logic [7:0] src_data;
  logic [7:0] ser_byte;

  assign ir_hit   = (test_ir_i == `IR_RECONFIG_PULSE);
  // instruction fires once on entry, the physical pin is not touched
  assign reconfig = !reconfig_request_n_i || (ir_hit && !state.ir_hit_last);
  // async host writes to one virtual address: chip select plus strobe edge
  assign ws_fall  = !ppa_i.chip_select_n && !ppa_i.write_strobe_n && state.ws_last;

  // =====================================================
  // byte source selection
  // one source per scheme, picked before the counters see it
  always_comb begin
    ser_byte  = {serial_data_i, state.shift[7:1]};
    src_valid = 1'b0;
    src_data  = 8'h00;
    case (scheme_i)
      scheme_passive_serial: begin
        // a byte completes on the eighth valid bit, lsb first
        src_valid = serial_valid_i && state.bits == 3'h7;
        src_data  = ser_byte;
      end
      scheme_passive_parallel_async: begin
        src_valid = ws_fall;
        src_data  = ppa_i.data;
      end
      scheme_fast_passive_parallel: begin
        src_valid = par_word_i.valid;
        src_data  = par_word_i.data;
      end
      scheme_test_port: begin
        src_valid = test_word_i.valid;
        src_data  = test_word_i.data;
      end
      default: begin
        // unused codes fall back to the attached memory
        src_valid = mem_word_i.valid;
        src_data  = mem_word_i.data;
      end
    endcase
  end

  // =====================================================
  // sequencing
  always_comb begin
    next_state             = state;
    wr_en                  = 1'b0;
    wr_data                = 8'h00;
    next_state.ws_last     = ppa_i.write_strobe_n;
    next_state.ir_hit_last = ir_hit;
    case (state.phase)
      st_por: begin
        // strap is sampled on the first enabled edge after reset
        if (!state.por_loaded) begin
          next_state.por_loaded = 1'b1;
          next_state.count      = reset_delay_select_i ? CW'(POR_SHORT) : CW'(POR_LONG);
        end else if (state.count == CW'(1)) begin
          next_state.phase = st_wait_chain;
        end else begin
          next_state.count = state.count - CW'(1);
        end
      end
      st_wait_chain: begin
        // data only flows once the preceding device hands over
        if (!chain_config_enable_in_n_i) begin
          next_state.phase = st_config;
          next_state.words = '0;
          next_state.bits  = 3'h0;
        end
      end
      st_config: begin
        // serial bits gather lsb first until a byte completes
        if (serial_valid_i && scheme_i == scheme_passive_serial) begin
          next_state.shift = ser_byte;
          next_state.bits  = state.bits + 3'h1;
        end
        wr_en   = src_valid;
        wr_data = src_data;
        if (wr_en) begin
          next_state.words = state.words + (AW+1)'(1);
          if (state.words == (AW+1)'(CFG_WORDS - 1)) begin
            next_state.phase      = st_init;
            next_state.count      = CW'(`INIT_CYCLES);
            next_state.chain_done = 1'b1;
          end
        end
      end
      st_init: begin
        // registers held in reset, then I/O released
        if (state.count == CW'(1)) begin
          next_state.phase = st_user;
        end else begin
          next_state.count = state.count - CW'(1);
        end
      end
      default: begin
        next_state.out_q  = user_out_i;
        next_state.oe_n_q = user_oe_n_i;
      end
    endcase
    if (reconfig && state.phase != st_por) begin
      next_state.phase      = st_wait_chain;
      next_state.chain_done = 1'b0;
      next_state.oe_n_q     = '1;
    end
    if (state.phase != st_user) begin
      next_state.oe_n_q = '1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state         <= '0;
      state.phase   <= st_por;
      state.ws_last <= 1'b1;
      state.oe_n_q  <= '1;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // =====================================================
  // outputs
  // per-pin drive, so one pin can be remapped on its own
  for (genvar g = 0; g < IO_WIDTH; g++) begin : g_pin
    assign io_out_o[g]  = state.out_q[g];
    assign io_oe_n_o[g] = state.oe_n_q[g];
  end
  assign io_pullup_en_o              = !weak_bias_select_n_i && state.phase != st_user;
  assign ppa_pins_owned_o            = state.phase != st_user;
  assign parallel_load_ready_o       = state.phase == st_config &&
                                       scheme_i == scheme_passive_parallel_async;
  assign chain_config_enable_out_n_o = !state.chain_done;
  assign user_mode_o                 = state.phase == st_user;
  assign init_reset_o                = state.phase == st_init;

  cfg_store #(
    .DEPTH (CFG_WORDS)
  ) u_store (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (wr_en),
    .waddr_i (state.words[AW-1:0]),
    .wdata_i (wr_data),
    .raddr_i (cfg_raddr_i),
    .rdata_o (cfg_rdata_o)
  );
endmodule

// ==== test/cfg_src.sv ====
`timescale 1ns/1ps
module cfg_src (
  // control
  input  wire logic                    clk_i,
  input  wire logic                    go_i,
  input  wire logic                    slow_i,
  input  wire cfg_loader_pkg::scheme_e scheme_i,
  // streams
  output cfg_loader_pkg::cfg_word_s    word_o,
  output logic                         ser_d_o,
  output logic                         ser_v_o,
  output cfg_loader_pkg::ppa_pins_s    ppa_o
);
  import cfg_loader_pkg::*;
  // ==========
  // source
  logic [7:0] n;
  logic [7:0] cur;
  logic [2:0] b;
  logic       send;
  initial ppa_o = '1;
  initial {word_o, ser_d_o, ser_v_o} = '0;
  always @(posedge clk_i) begin
    cur = 8'h3C ^ (n * 8'h1D);
    // async strobe must rise between bytes
    send = go_i && !(slow_i && $urandom_range(1, 0)) &&
      (scheme_i != scheme_passive_parallel_async || ppa_o.write_strobe_n);
    // idle lines show inverted data, never a stale copy
    word_o <= send ? {1'b1, cur} : {1'b0, ~word_o.data};
    ser_v_o <= send;
    ser_d_o <= send ? cur[b] : ~ser_d_o;
    ppa_o <= send ? {2'b00, 1'b1, cur} : {3'b111, ~ppa_o.data};
    b <= go_i ? b + 3'(send) : 3'h0;
    if (!go_i) n <= 8'h00;
    else if (send && (scheme_i != scheme_passive_serial || b == 3'h7)) n <= n + 8'h01;
  end
endmodule

// ==== test/cfg_mode_ctrl_chk.sv ====
`timescale 1ns/1ps
module cfg_mode_ctrl_chk #(
  parameter int IO_WIDTH = 8
) (
  // clock and reset
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  // watched pins
  input wire logic                    reconfig_request_n_i,
  input wire logic                    weak_bias_select_n_i,
  input wire logic [9:0]              test_ir_i,
  input wire cfg_loader_pkg::scheme_e scheme_i,
  input wire logic                    chain_config_enable_out_n_o,
  input wire logic                    parallel_load_ready_o,
  input wire logic [IO_WIDTH-1:0]     io_oe_n_o,
  input wire logic                    io_pullup_en_o,
  input wire logic                    ppa_pins_owned_o,
  input wire logic                    user_mode_o,
  input wire logic                    init_reset_o
);
  import cfg_loader_pkg::*;
  // ==========
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // oe is registered, so allow one cycle of lag on leaving user mode
  chk_io_hiz: assert property (!user_mode_o && !$past(user_mode_o) |-> &io_oe_n_o)
    else $error("io driven in command mode");
  chk_pullup_sel: assert property (
    io_pullup_en_o == (!user_mode_o && !weak_bias_select_n_i)) else $error("pull-up wrong");
  chk_ppa_owner: assert property (ppa_pins_owned_o == !user_mode_o)
    else $error("parallel pin owner wrong");
  chk_init_len: assert property (
    $rose(init_reset_o) |-> (!user_mode_o) [*8] ##9 (user_mode_o && !init_reset_o))
    else $error("init length wrong");
  chk_chain_after: assert property ($fell(chain_config_enable_out_n_o) |-> $rose(init_reset_o))
    else $error("chain out early");
  chk_reconfig_pin: assert property (
    user_mode_o && !reconfig_request_n_i |=> !user_mode_o ##1 chain_config_enable_out_n_o)
    else $error("reconfig pin ignored");
  chk_ir_pulse: assert property (
    user_mode_o && test_ir_i == 10'h001 && $past(test_ir_i) != 10'h001 |=> !user_mode_o)
    else $error("reconfig instruction ignored");
  chk_ready_when: assert property (parallel_load_ready_o |-> !user_mode_o &&
    !init_reset_o && scheme_i == scheme_passive_parallel_async) else $error("ready wrong");
  cov_init: cover property ($rose(init_reset_o));
  cov_pin: cover property (user_mode_o && !reconfig_request_n_i);
  cov_ir: cover property (user_mode_o && test_ir_i == 10'h001);
endmodule
bind cfg_mode_ctrl cfg_mode_ctrl_chk #(.IO_WIDTH(IO_WIDTH)) cfg_mode_ctrl_chk_i (
  .clk_i                       (clk_i),
  .rst_i                       (rst_i),
  .reconfig_request_n_i        (reconfig_request_n_i),
  .weak_bias_select_n_i        (weak_bias_select_n_i),
  .test_ir_i                   (test_ir_i),
  .scheme_i                    (scheme_i),
  .chain_config_enable_out_n_o (chain_config_enable_out_n_o),
  .parallel_load_ready_o       (parallel_load_ready_o),
  .io_oe_n_o                   (io_oe_n_o),
  .io_pullup_en_o              (io_pullup_en_o),
  .ppa_pins_owned_o            (ppa_pins_owned_o),
  .user_mode_o                 (user_mode_o),
  .init_reset_o                (init_reset_o)
);

// ==== test/fpga_config_mode_control_tb_top.sv ====
`timescale 1ns/1ps
module fpga_config_mode_control_tb_top;
  import cfg_loader_pkg::*;
  // ==========
  // wiring
  localparam int W = 4;
  logic clk = 1'b0, rst = 1'b1, rds = 1'b0, wbs = 1'b0, rq_n = 1'b1, cin_n = 1'b1;
  logic go = 1'b0, slow = 1'b0, ce = 1'b1, sd, sv, cout_n, rdy, pu, own, um, ini;
  logic [9:0] ir = 10'h000;
  logic [7:0] uo = 8'h00, uoe = 8'hFF, io, ioe, rd;
  logic [1:0] ra = 2'h0;
  scheme_e    sch = scheme_memory;
  cfg_word_s  w;
  ppa_pins_s  pp;
  int         miscompares = 0, checks = 0, c;
  initial forever #12.5 clk = ~clk;
  cfg_src cfg_src_i (.clk_i(clk), .go_i(go), .slow_i(slow), .scheme_i(sch), .word_o(w),
    .ser_d_o(sd), .ser_v_o(sv), .ppa_o(pp));
  // short counts keep the run brief
  cfg_mode_ctrl #(.CFG_WORDS(W), .POR_LONG(20), .POR_SHORT(4)) cfg_mode_ctrl_i (
    .clk_i(clk), .rst_i(rst), .ce_i(ce), .reset_delay_select_i(rds),
    .weak_bias_select_n_i(wbs), .scheme_i(sch), .reconfig_request_n_i(rq_n),
    .test_ir_i(ir), .chain_config_enable_in_n_i(cin_n), .chain_config_enable_out_n_o(cout_n),
    .serial_data_i(sd), .serial_valid_i(sv), .par_word_i(w), .mem_word_i(w),
    .test_word_i(w), .ppa_i(pp), .parallel_load_ready_o(rdy), .user_out_i(uo),
    .user_oe_n_i(uoe), .io_out_o(io), .io_oe_n_o(ioe), .io_pullup_en_o(pu),
    .ppa_pins_owned_o(own), .user_mode_o(um), .init_reset_o(ini), .cfg_raddr_i(ra),
    .cfg_rdata_o(rd));
  // ==========
  // tasks
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_hi(ref logic s);
    c = 0;
    while (s !== 1'b1) begin
      @(negedge clk);
      c++;
      if (c > 300) begin
        miscompares++;
        final_report();
      end
    end
  endtask
  task automatic reset(input logic sel);
    @(posedge clk);
    rst <= 1'b1;
    rds <= sel;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic load();
    @(posedge clk);
    go <= 1'b1;
    @(negedge clk);
    chk(rdy === (sch == scheme_passive_parallel_async), "ready flag");
    wait_hi(um);
    @(posedge clk);
    go <= 1'b0;
  endtask
  function automatic logic [7:0] exp_b(input int n);
    return 8'h3C ^ 8'(n * 29);
  endfunction
  // ==========
  // sequence
  initial begin
    void'($urandom(76));
    for (int s = 0; s < 5; s++) begin
      @(posedge clk);
      sch <= scheme_e'(s);
      {wbs, slow} <= 2'($urandom);
      {uo, uoe} <= 16'($urandom);
      cin_n <= 1'b1;
      reset(1'($urandom));
      repeat (25) @(posedge clk);
      @(negedge clk);
      chk(um === 1'b0 && cout_n === 1'b1, "loaded without chain enable");
      chk(ioe === 8'hFF && pu === !wbs && rdy === 1'b0, "pins before config");
      @(posedge clk);
      cin_n <= 1'b0;
      load();
      @(negedge clk);
      chk(cout_n === 1'b0 && own === 1'b0 && pu === 1'b0, "user pins");
      chk(ioe === uoe && io === uo, "user io");
      for (int i = 0; i < W; i++) begin
        @(posedge clk);
        ra <= 2'(i);
        @(posedge clk);
        @(negedge clk);
        chk(rd === exp_b(i), "stored byte");
      end
      @(posedge clk);
      if (s[0]) ir <= 10'h001;
      else rq_n <= 1'b0;
      @(posedge clk);
      {ir, rq_n} <= {10'h000, 1'b1};
      repeat (2) @(negedge clk);
      chk(um === 1'b0 && ioe === 8'hFF && cout_n === 1'b1, "reconfig");
      load();
      @(negedge clk);
      chk(um === 1'b1, "reload");
    end
    @(posedge clk);
    {sch, slow} <= {scheme_fast_passive_parallel, 1'b0};
    for (int p = 0; p < 2; p++) begin
      reset(p[0]);
      // a frozen block must not count its power-on wait
      ce <= 1'b0;
      repeat (8) @(posedge clk);
      ce <= 1'b1;
      go <= 1'b1;
      wait_hi(ini);
      chk(c >= (p ? 4 : 20) + W && c <= (p ? 4 : 20) + W + 5, "reset delay");
      @(posedge clk);
      go <= 1'b0;
    end
    final_report();
  end
endmodule
